/* sdm_status_diag.v */
// Status, self-diagnostic, timestamp and multidrop logic of the transmitter.
// Assumes a 10 MHz clock, synchronous reset at power-on, inputs synchronous.
//
// Summary of operation
// - Polling address zero leaves multidrop and returns to point-to-point.
// - Self-test request checks errors; reports them, or pass if none.
// - Groups 0-5,14 module 1; 15-16 diagnostics; 17 simulation; 18-23 module 2.
// - With several errors the indicator shows each for three seconds.
// - Device status word summarises extended and diagnostic status.
// - Each of seven variables carries data quality and limit status.
// - Quality good normally; bad or poor on fault or out of range.
// - Limit status constant when value not changing.
// - Running day count from power-on plus running time of day.
// - Date and time counters clear at every power-on.
// - Each change or calibration increments a never-cleared change counter.
// - Config-changed is status bit 0x40; reset command or power-on reset clears it.
// - Multidrop active whenever polling address is 1 to 63.
// - Loop current mode disabled holds analog output at 4 mA.
// - Any setting change sets config-changed and bumps the counter.
`include "sdm_defs.vh"
module sdm_status_diag (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire [5:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [`SDM_NERR-1:0] i_dev_err,
    input wire [`SDM_NERR-1:0] i_cfg_err,
    input wire [7:0] i_ext_stat,
    input wire [15:0] i_diag_stat,
    input wire [`SDM_NVAR-1:0] i_sens_fault,
    input wire [`SDM_NVAR-1:0] i_out_range,
    input wire [`SDM_NVAR-1:0] i_fixed,
    input wire [`SDM_NVAR-1:0] i_at_low,
    input wire [`SDM_NVAR-1:0] i_at_high,
    input wire [`SDM_NVAR-1:0] i_unchanged,
    input wire i_calib_done,
    input wire [31:0] i_nv_chg_cnt,
    input wire i_grp_we,
    input wire [4:0] i_grp_idx,
    input wire [7:0] i_grp_bits,
    output reg [31:0] o_rdata,
    output reg o_multidrop,
    output reg o_loop_fixed_4ma,
    output reg [31:0] o_nv_chg_cnt,
    output reg o_nv_wr,
    output reg [3:0] o_ind_err,
    output reg o_ind_err_valid,
    output reg o_irq
);
    // Self-test sequencer states
    localparam ST_IDLE = 2'b00;
    localparam ST_CHECK = 2'b01;
    localparam ST_DONE = 2'b10;

    localparam [31:0] SEC_CYC_W = `SDM_SEC_CYC - 1;
    localparam [31:0] ROT_LAST_W = `SDM_ROT_S - 1;
    localparam [31:0] DAY_LAST_W = `SDM_DAY_SEC - 1;
    localparam [23:0] SEC_CYC = SEC_CYC_W[23:0];
    localparam [1:0] ROT_LAST = ROT_LAST_W[1:0];
    localparam [16:0] DAY_LAST = DAY_LAST_W[16:0];

    reg [5:0] poll_q;
    reg loop_en_q;
    reg cfg_chg_q;
    reg [31:0] chg_cnt_q;
    reg [31:0] days_q;
    reg [16:0] tod_q;
    reg [23:0] sec_div_q;
    reg [1:0] rot_sec_q;
    reg [3:0] ind_idx_q;
    reg [1:0] st_q;
    reg [15:0] test_err_q;
    reg test_pass_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_mask_q;
    reg rd_grp_q;
    reg [`SDM_NVAR-1:0] err_seen_q;
    reg [2*`SDM_NVAR-1:0] dq_q;
    reg [2*`SDM_NVAR-1:0] ls_q;

    wire [15:0] act_err = i_dev_err | i_cfg_err;
    wire [7:0] grp_rdata;
    wire sec_tick = (sec_div_q == SEC_CYC);
    wire wr_setting = i_wr && (i_addr == `SDM_A_POLL ||
        (i_addr == `SDM_A_CTRL && i_wdata[`SDM_CTRL_LOOP_EN] != loop_en_q));
    wire chg_ev = wr_setting || i_calib_done;
    wire cfg_clr = i_wr && i_addr == `SDM_A_CTRL &&
        i_wdata[`SDM_CTRL_CFG_CLR];
    wire test_req = i_wr && i_addr == `SDM_A_CTRL &&
        i_wdata[`SDM_CTRL_SELFTEST];
    wire irq_rd = i_rd && i_addr == `SDM_A_IRQ_STAT;

    // Next active error above the current one, wrapping to the lowest
    function [4:0] next_err;
        input [15:0] act;
        input [3:0] cur;
        integer k;
        reg found;
        reg [3:0] j;
        begin
            found = 1'b0;
            next_err = 5'h00;
            for (k = 1; k <= 16; k = k + 1) begin
                j = cur + k[3:0];
                if (!found && act[j]) begin
                    found = 1'b1;
                    next_err = {1'b1, j};
                end
            end
        end
    endfunction

    // Device status word folded from extended and diagnostic status
    function [7:0] dev_status;
        input cfg;
        input [7:0] ext;
        input [15:0] diag;
        input [15:0] err;
        begin
            dev_status = 8'h00;
            dev_status[`SDM_DS_CFG_CHG] = cfg;
            dev_status[`SDM_DS_MORE_STAT] = (|ext) | (|diag);
            dev_status[`SDM_DS_MALFUNC] = |err;
        end
    endfunction

    wire [4:0] nxt = next_err(act_err, ind_idx_q);
    wire [7:0] dstat = dev_status(cfg_chg_q, i_ext_stat, i_diag_stat,
        act_err);

    // Polling address, loop mode and derived output modes
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            poll_q <= 6'h00;
            loop_en_q <= 1'b1;
            o_multidrop <= 1'b0;
            o_loop_fixed_4ma <= 1'b0;
        end else begin
            if (i_wr && i_addr == `SDM_A_POLL)
                poll_q <= i_wdata[5:0];
            if (i_wr && i_addr == `SDM_A_CTRL)
                loop_en_q <= i_wdata[`SDM_CTRL_LOOP_EN];
            // Zero means point-to-point; 1..63 means multidrop
            o_multidrop <= (poll_q != 6'h00) &&
                (poll_q <= `SDM_POLL_MAX);
            o_loop_fixed_4ma <= !loop_en_q;
        end
    end

    // Config-changed flag: a change in the clear cycle wins
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            cfg_chg_q <= 1'b0;
        end else if (chg_ev) begin
            cfg_chg_q <= 1'b1;
        end else if (cfg_clr) begin
            cfg_chg_q <= 1'b0;
        end
    end

    // Change counter resumes from non-volatile copy; never cleared
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            chg_cnt_q <= 32'h00000000;
            o_nv_chg_cnt <= 32'h00000000;
            o_nv_wr <= 1'b0;
            rd_grp_q <= 1'b0;
        end else begin
            rd_grp_q <= 1'b1;
            // Stored copy moves only with a store once the power-on load is done, so the port stays quiet
            if (!rd_grp_q) begin
                chg_cnt_q <= i_nv_chg_cnt;
                o_nv_chg_cnt <= i_nv_chg_cnt;
            end else if (chg_ev) begin
                chg_cnt_q <= chg_cnt_q + 32'h00000001;
                o_nv_chg_cnt <= chg_cnt_q + 32'h00000001;
            end
            o_nv_wr <= rd_grp_q && chg_ev;
        end
    end

    // Running date and time of day, cleared at power-on
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            sec_div_q <= 24'h000000;
            tod_q <= 17'h00000;
            days_q <= 32'h00000000;
        end else begin
            sec_div_q <= sec_tick ? 24'h000000 : sec_div_q + 24'h000001;
            if (sec_tick) begin
                if (tod_q == DAY_LAST) begin
                    tod_q <= 17'h00000;
                    days_q <= days_q + 32'h00000001;
                end else begin
                    tod_q <= tod_q + 17'h00001;
                end
            end
        end
    end

    // Indicator rotation: three seconds per active error, ascending
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rot_sec_q <= 2'b00;
            ind_idx_q <= 4'h0;
            o_ind_err <= 4'h0;
            o_ind_err_valid <= 1'b0;
        end else begin
            if (act_err == 16'h0000) begin
                rot_sec_q <= 2'b00;
            end else if (!act_err[ind_idx_q]) begin
                // Shown error vanished; jump at once
                ind_idx_q <= nxt[3:0];
                rot_sec_q <= 2'b00;
            end else if (sec_tick) begin
                if (rot_sec_q == ROT_LAST) begin
                    rot_sec_q <= 2'b00;
                    ind_idx_q <= nxt[3:0];
                end else begin
                    rot_sec_q <= rot_sec_q + 2'b01;
                end
            end
            o_ind_err <= ind_idx_q;
            o_ind_err_valid <= act_err[ind_idx_q];
        end
    end

    // Self-test: snapshot errors, report pass when none
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            st_q <= ST_IDLE;
            test_err_q <= 16'h0000;
            test_pass_q <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: if (test_req) st_q <= ST_CHECK;
                ST_CHECK: begin
                    test_err_q <= act_err;
                    test_pass_q <= (act_err == 16'h0000);
                    st_q <= ST_DONE;
                end
                ST_DONE: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Per-variable quality and limit status
    genvar v;
    generate
        for (v = 0; v < `SDM_NVAR; v = v + 1) begin : g_var
            always @(posedge i_clk_sys) begin
                if (!i_rstn) begin
                    dq_q[2*v+1:2*v] <= `SDM_DQ_GOOD;
                    ls_q[2*v+1:2*v] <= `SDM_LS_NONE;
                end else begin
                    // Sensor fault outranks out-of-range
                    if (i_sens_fault[v])
                        dq_q[2*v+1:2*v] <= `SDM_DQ_BAD;
                    else if (i_out_range[v])
                        dq_q[2*v+1:2*v] <= `SDM_DQ_POOR;
                    else if (i_fixed[v])
                        dq_q[2*v+1:2*v] <= `SDM_DQ_MANUAL;
                    else
                        dq_q[2*v+1:2*v] <= `SDM_DQ_GOOD;
                    if (i_unchanged[v])
                        ls_q[2*v+1:2*v] <= `SDM_LS_CONST;
                    else if (i_at_low[v])
                        ls_q[2*v+1:2*v] <= `SDM_LS_LOW;
                    else if (i_at_high[v])
                        ls_q[2*v+1:2*v] <= `SDM_LS_HIGH;
                    else
                        ls_q[2*v+1:2*v] <= `SDM_LS_NONE;
                end
            end
        end
    endgenerate

    // Sticky events, cleared by reading; a new event wins the read
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            irq_stat_q <= 3'b000;
            irq_mask_q <= 3'b000;
            err_seen_q <= {`SDM_NVAR{1'b0}};
            o_irq <= 1'b0;
        end else begin
            err_seen_q <= i_sens_fault;
            irq_stat_q <= (irq_rd ? 3'b000 : irq_stat_q) |
                {st_q == ST_CHECK, |(i_sens_fault & ~err_seen_q), chg_ev};
            if (i_wr && i_addr == `SDM_A_IRQ_MASK)
                irq_mask_q <= i_wdata[2:0];
            o_irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Status groups 0..23 mapped by index; writer owns placement
    wire [5:0] grp_off = i_addr - `SDM_A_GRP_BASE;
    sdm_grp_mem u_grp (
        .i_clk_sys(i_clk_sys),
        .i_we(i_grp_we),
        .i_waddr(i_grp_idx),
        .i_wdata(i_grp_bits),
        .i_raddr(grp_off[4:0]),
        .o_rdata(grp_rdata)
    );

    // Read data one cycle after the strobe; zero otherwise
    reg [31:0] rd_mux;
    reg rd_grp_d;
    reg rd_q;
    always @* begin
        rd_mux = 32'h00000000;
        case (i_addr)
            `SDM_A_POLL: rd_mux = {26'h0, poll_q};
            `SDM_A_CTRL: rd_mux = {31'h0, loop_en_q};
            `SDM_A_DEV_STAT: rd_mux = {24'h0, dstat};
            `SDM_A_EXT_STAT: rd_mux = {24'h0, i_ext_stat};
            `SDM_A_DIAG_STAT: rd_mux = {16'h0, i_diag_stat};
            `SDM_A_CHG_CNT: rd_mux = chg_cnt_q;
            `SDM_A_DAYS: rd_mux = days_q;
            `SDM_A_TOD: rd_mux = {15'h0, tod_q};
            `SDM_A_ERR_SHOW: rd_mux = {16'h0, act_err};
            `SDM_A_SELFTEST: rd_mux = {15'h0, test_pass_q, test_err_q};
            `SDM_A_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
            `SDM_A_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
            `SDM_A_VAR_STAT: rd_mux = {4'h0, ls_q, dq_q};
            default: rd_mux = 32'h00000000;
        endcase
        rd_grp_d = i_addr >= `SDM_A_GRP_BASE &&
            i_addr < `SDM_A_GRP_BASE + `SDM_NGRP;
    end

    reg [31:0] rd_hold_q;
    reg rd_sel_q;
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rd_hold_q <= 32'h00000000;
            rd_sel_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            rd_q <= i_rd;
            rd_sel_q <= rd_grp_d;
            rd_hold_q <= i_rd ? rd_mux : 32'h00000000;
        end
    end

    // Group memory read is already registered, so merge combinationally
    always @* begin
        if (!rd_q)
            o_rdata = 32'h00000000;
        else if (rd_sel_q)
            o_rdata = {24'h0, grp_rdata};
        else
            o_rdata = rd_hold_q;
    end
endmodule

/* sdm_defs.vh */
// Constants for the status and diagnostics block of the pressure transmitter.
// Assumes a 10 MHz system clock and a plain register port.
`ifndef SDM_DEFS_VH
`define SDM_DEFS_VH

// Register word indices (byte-free plain port, 6-bit address)
// Six bits so that all 24 status groups sit above the registers
`define SDM_A_POLL 6'h00
`define SDM_A_CTRL 6'h01
`define SDM_A_DEV_STAT 6'h02
`define SDM_A_EXT_STAT 6'h03
`define SDM_A_DIAG_STAT 6'h04
`define SDM_A_CHG_CNT 6'h05
`define SDM_A_DAYS 6'h06
`define SDM_A_TOD 6'h07
`define SDM_A_ERR_SHOW 6'h08
`define SDM_A_SELFTEST 6'h09
`define SDM_A_IRQ_STAT 6'h0A
`define SDM_A_IRQ_MASK 6'h0B
`define SDM_A_VAR_STAT 6'h0C
`define SDM_A_GRP_BASE 6'h10

// Control register bits
`define SDM_CTRL_LOOP_EN 0
`define SDM_CTRL_SELFTEST 1
`define SDM_CTRL_CFG_CLR 2

// Device status word fields
`define SDM_DS_CFG_CHG 6
`define SDM_DS_MORE_STAT 4
`define SDM_DS_MALFUNC 7
`define SDM_DS_CFG_CHG_VAL 8'h40

// Multidrop address range
`define SDM_POLL_MAX 6'h3F

// Data quality codes
`define SDM_DQ_BAD 2'h0
`define SDM_DQ_POOR 2'h1
`define SDM_DQ_MANUAL 2'h2
`define SDM_DQ_GOOD 2'h3
// Limit status codes
`define SDM_LS_NONE 2'h0
`define SDM_LS_LOW 2'h1
`define SDM_LS_HIGH 2'h2
`define SDM_LS_CONST 2'h3

// Number of variables and status groups
`define SDM_NVAR 7
`define SDM_NGRP 24
`define SDM_NERR 16

// Timing: one second, three-second indicator step
`define SDM_CLK_HZ 10000000
`define SDM_SEC_S 1
`define SDM_SEC_CYC (`SDM_CLK_HZ * `SDM_SEC_S)
`define SDM_ROT_S 3
`define SDM_DAY_SEC 86400

// Interrupt bits
`define SDM_IRQ_CFG 0
`define SDM_IRQ_ERR 1
`define SDM_IRQ_TEST 2

`endif

/* sdm_grp_mem.v */
// Status group store: 24 bytes of group bits, registered read data.
// Assumes one clock and the writer updates one group per cycle.
`include "sdm_defs.vh"
module sdm_grp_mem (
    input wire i_clk_sys,
    input wire i_we,
    input wire [4:0] i_waddr,
    input wire [7:0] i_wdata,
    input wire [4:0] i_raddr,
    output reg [7:0] o_rdata
);
    reg [7:0] mem_q [0:`SDM_NGRP-1];

    // Write and registered read; out-of-range indices read as zero
    always @(posedge i_clk_sys) begin
        if (i_we && i_waddr < `SDM_NGRP)
            mem_q[i_waddr] <= i_wdata;
        if (i_raddr < `SDM_NGRP)
            o_rdata <= mem_q[i_raddr];
        else
            o_rdata <= 8'h00;
    end
endmodule

/* sdm_status_diag_sva.sv */
// Checker of the status block, watching top-level ports only.
// Assumes one clock domain; bound to every instance after the module.
`include "sdm_defs.vh"
module sdm_status_diag_sva (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire [5:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [`SDM_NERR-1:0] i_dev_err,
    input wire [`SDM_NERR-1:0] i_cfg_err,
    input wire [31:0] o_rdata,
    input wire o_multidrop,
    input wire o_loop_fixed_4ma,
    input wire [31:0] o_nv_chg_cnt,
    input wire o_nv_wr,
    input wire [3:0] o_ind_err,
    input wire o_ind_err_valid,
    input wire o_irq
);
    // Errors the indicator may legally show
    wire [15:0] act = i_dev_err | i_cfg_err;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    // Poll address write, split by value
    sequence poll_wr_s;
        i_wr && i_addr == `SDM_A_POLL;
    endsequence
    sequence poll_on_s;
        poll_wr_s ##0 i_wdata[5:0] != 6'h00;
    endsequence
    sequence poll_off_s;
        poll_wr_s ##0 i_wdata[5:0] == 6'h00;
    endsequence
    rd_slot_only_a: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data outside read slot");
    multidrop_on_a: assert property (poll_on_s |=> ##1 o_multidrop)
        else $error("multidrop not entered");
    multidrop_off_a: assert property (poll_off_s |=> ##1 !o_multidrop)
        else $error("multidrop not left");
    change_store_a: assert property (poll_wr_s |=> o_nv_wr)
        else $error("setting change not stored");
    count_step_a: assert property (
        o_nv_wr |-> o_nv_chg_cnt == $past(o_nv_chg_cnt) + 32'h1)
        else $error("change count not stepped by one");
    count_hold_a: assert property (
        $past(i_rstn, 2) && !o_nv_wr |-> $stable(o_nv_chg_cnt))
        else $error("change count moved without a store");
    count_read_a: assert property (i_rd && i_addr == `SDM_A_CHG_CNT
        |=> o_rdata == $past(o_nv_chg_cnt))
        else $error("change count read wrong");
    loop_fixed_a: assert property (i_wr && i_addr == `SDM_A_CTRL
        && !i_wdata[`SDM_CTRL_LOOP_EN] |=> ##1 o_loop_fixed_4ma)
        else $error("analog output not fixed");
    irq_masked_a: assert property (i_wr && i_addr == `SDM_A_IRQ_MASK
        && i_wdata[2:0] == 3'h0 |=> ##2 !o_irq)
        else $error("interrupt despite full mask");
    shown_active_a: assert property (o_ind_err_valid && $stable(act)
        && act == $past(act, 2) |-> act[o_ind_err])
        else $error("indicator shows an inactive error");
    shown_live_a: assert property ($past(i_rstn, 2) && $past(i_rstn)
        && $past(act) != 16'h0 && $past(act) == $past(act, 2)
        |-> o_ind_err_valid)
        else $error("active errors but none shown");
endmodule

bind sdm_status_diag sdm_status_diag_sva u_sva (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_dev_err(i_dev_err),
    .i_cfg_err(i_cfg_err), .o_rdata(o_rdata), .o_multidrop(o_multidrop),
    .o_loop_fixed_4ma(o_loop_fixed_4ma), .o_nv_chg_cnt(o_nv_chg_cnt),
    .o_nv_wr(o_nv_wr), .o_ind_err(o_ind_err),
    .o_ind_err_valid(o_ind_err_valid), .o_irq(o_irq)
);

/* sdm_host.sv */
// Host configuration tool model driving the register port.
// Assumes read data stand only in the cycle after the read strobe.
`include "sdm_defs.vh"
module sdm_host (
    input wire i_clk_sys,
    input wire [31:0] i_rdata,
    output logic [5:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus from time zero
    initial begin
        o_addr = 6'h00;
        o_wdata = 32'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // One-cycle write strobe
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= v;
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
    endtask
    // One-cycle read strobe, answer taken once settled
    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        @(posedge i_clk_sys);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk_sys);
        o_rd <= 1'b0;
        #1 v = i_rdata;
    endtask
    // Leaving multidrop also restores tracking analog output
    task automatic leave_multidrop;
        wr(`SDM_A_POLL, 32'h0);
        wr(`SDM_A_CTRL, 32'h1);
    endtask
endmodule

/* testbench.sv */
// Self-checking bench of the status and diagnostics block.
// Assumes the host model as bus master and a 10 MHz clock.
`include "sdm_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] NV = 32'h0000_0010;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic [5:0] i_addr;
    logic [4:0] i_grp_idx;
    logic [31:0] i_wdata, o_rdata, o_nv_chg_cnt, cnt, d;
    logic i_wr, i_rd, i_calib_done, i_grp_we;
    logic [15:0] i_dev_err, i_cfg_err, i_diag_stat;
    logic [7:0] i_ext_stat, i_grp_bits;
    logic [6:0] i_sens_fault, i_out_range, i_fixed;
    logic [6:0] i_at_low, i_at_high, i_unchanged;
    logic o_multidrop, o_loop_fixed_4ma, o_nv_wr, o_ind_err_valid, o_irq;
    logic [3:0] o_ind_err;
    int mismatches = 0;
    int checks_done = 0;
    // 100 ns period
    always #50 i_clk_sys = ~i_clk_sys;
    sdm_status_diag u_sdm_status_diag (
        .i_clk_sys, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .i_dev_err,
        .i_cfg_err, .i_ext_stat, .i_diag_stat, .i_sens_fault, .i_out_range,
        .i_fixed, .i_at_low, .i_at_high, .i_unchanged, .i_calib_done,
        .i_nv_chg_cnt(NV), .i_grp_we, .i_grp_idx, .i_grp_bits, .o_rdata,
        .o_multidrop, .o_loop_fixed_4ma, .o_nv_chg_cnt, .o_nv_wr,
        .o_ind_err, .o_ind_err_valid, .o_irq
    );
    sdm_host u_sdm_host (.i_clk_sys, .i_rdata(o_rdata), .o_addr(i_addr),
        .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // Read, mask and compare one register
    task automatic rdc(input string n, input logic [5:0] a,
                       input logic [31:0] m, input logic [31:0] e);
        u_sdm_host.rd(a, d);
        chk(n, e, d & m);
    endtask
    // Let n edges pass, then settle
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic results;
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_power_on;
        rdc("poll", `SDM_A_POLL, 32'h3F, 32'h0);
        rdc("count", `SDM_A_CHG_CNT, 32'hFFFFFFFF, NV);
        rdc("days", `SDM_A_DAYS, 32'hFFFFFFFF, 32'h0);
        rdc("time", `SDM_A_TOD, 32'hFFFFFFFF, 32'h0);
        chk("multidrop", 1'b0, o_multidrop);
        chk("fixed 4mA", 1'b0, o_loop_fixed_4ma);
    endtask
    task automatic t_multidrop;
        u_sdm_host.wr(`SDM_A_POLL, 32'h5);
        cyc(2);
        chk("multidrop 5", 1'b1, o_multidrop);
        u_sdm_host.wr(`SDM_A_POLL, 32'h3F);
        cyc(2);
        chk("multidrop 63", 1'b1, o_multidrop);
        rdc("cfg flag", `SDM_A_DEV_STAT, 32'h40, 32'h40);
        u_sdm_host.leave_multidrop();
        cyc(1);
        chk("multidrop 0", 1'b0, o_multidrop);
        u_sdm_host.wr(`SDM_A_CTRL, 32'h0);
        cyc(2);
        chk("fixed 4mA", 1'b1, o_loop_fixed_4ma);
        u_sdm_host.wr(`SDM_A_CTRL, 32'h1);
        @(posedge i_clk_sys) i_calib_done <= 1'b1;
        @(posedge i_clk_sys) i_calib_done <= 1'b0;
        cnt = NV + 32'h6;
        rdc("count", `SDM_A_CHG_CNT, 32'hFFFFFFFF, cnt);
        chk("stored count", cnt, o_nv_chg_cnt);
        u_sdm_host.wr(`SDM_A_CTRL, 32'h5);
        rdc("cfg flag", `SDM_A_DEV_STAT, 32'h40, 32'h0);
        u_sdm_host.wr(`SDM_A_CHG_CNT, 32'h0);
        rdc("count", `SDM_A_CHG_CNT, 32'hFFFFFFFF, cnt);
    endtask
    task automatic t_irq;
        u_sdm_host.wr(`SDM_A_IRQ_MASK, 32'h1);
        rdc("irq drain", `SDM_A_IRQ_STAT, 32'h7, 32'h1);
        u_sdm_host.wr(`SDM_A_POLL, 32'h0);
        cyc(2);
        chk("irq", 1'b1, o_irq);
        rdc("irq status", `SDM_A_IRQ_STAT, 32'h1, 32'h1);
        cyc(2);
        chk("irq cleared", 1'b0, o_irq);
        u_sdm_host.wr(`SDM_A_IRQ_MASK, 32'h0);
        u_sdm_host.wr(`SDM_A_POLL, 32'h0);
        cyc(3);
        chk("irq masked", 1'b0, o_irq);
        rdc("unmapped", 6'h3F, 32'hFFFFFFFF, 32'h0);
    endtask
    // Distinct condition per variable, rest left plain
    task automatic t_quality;
        @(posedge i_clk_sys);
        i_sens_fault <= 7'h01;
        i_out_range <= 7'h02;
        i_fixed <= 7'h04;
        i_unchanged <= 7'h01;
        i_at_low <= 7'h02;
        i_at_high <= 7'h04;
        cyc(2);
        u_sdm_host.rd(`SDM_A_VAR_STAT, d);
        chk("quality 0", `SDM_DQ_BAD, d[1:0]);
        chk("quality 1", `SDM_DQ_POOR, d[3:2]);
        chk("quality 2", `SDM_DQ_MANUAL, d[5:4]);
        chk("limit 0", `SDM_LS_CONST, d[15:14]);
        chk("limit 1", `SDM_LS_LOW, d[17:16]);
        chk("limit 2", `SDM_LS_HIGH, d[19:18]);
        for (int k = 3; k < 7; k++) begin
            chk("quality", `SDM_DQ_GOOD, d[2*k +: 2]);
            chk("limit", `SDM_LS_NONE, d[14+2*k +: 2]);
        end
        rdc("fault irq", `SDM_A_IRQ_STAT, 32'h2, 32'h2);
    endtask
    task automatic t_selftest;
        u_sdm_host.wr(`SDM_A_CTRL, 32'h3);
        cyc(2);
        rdc("self pass", `SDM_A_SELFTEST, 32'h1FFFF, 32'h10000);
        @(posedge i_clk_sys);
        i_dev_err <= 16'h0024;
        i_cfg_err <= 16'h0100;
        i_ext_stat <= 8'h01;
        i_diag_stat <= 16'h0200;
        u_sdm_host.wr(`SDM_A_CTRL, 32'h3);
        cyc(2);
        rdc("self errs", `SDM_A_SELFTEST, 32'h1FFFF, 32'h00124);
        rdc("summary", `SDM_A_DEV_STAT, 32'h90, 32'h90);
        rdc("ext", `SDM_A_EXT_STAT, 32'hFF, 32'h01);
        rdc("diag", `SDM_A_DIAG_STAT, 32'hFFFF, 32'h0200);
        for (int k = 0; k < 8 && o_ind_err_valid !== 1'b1; k++)
            cyc(1);
        chk("shown valid", 1'b1, o_ind_err_valid);
        chk("shown error", 32'h2, o_ind_err);
    endtask
    task automatic t_groups;
        for (int k = 0; k < 24; k++) begin
            @(posedge i_clk_sys);
            i_grp_we <= 1'b1;
            i_grp_idx <= 5'(k);
            i_grp_bits <= 8'hC3 ^ 8'(k);
        end
        @(posedge i_clk_sys) i_grp_we <= 1'b0;
        for (int k = 0; k < 24; k++)
            rdc("group", `SDM_A_GRP_BASE + 6'(k), 32'hFF,
                32'(8'hC3 ^ 8'(k)));
    endtask
    // Cuts a hung run short
    initial begin
        #5000000;
        mismatches++;
        results();
    end
    // Reset, then scenarios in turn
    initial begin
        {i_dev_err, i_cfg_err, i_diag_stat, i_ext_stat} = '0;
        {i_sens_fault, i_out_range, i_fixed} = '0;
        {i_at_low, i_at_high, i_unchanged} = '0;
        {i_calib_done, i_grp_we, i_grp_idx, i_grp_bits} = '0;
        repeat (5) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        cyc(1);
        t_power_on();
        t_multidrop();
        t_irq();
        t_quality();
        t_selftest();
        t_groups();
        results();
    end
endmodule
